// ---- design/fspc_pkg.sv ----
// constants, types and register map of the flash self program control
package fspc_pkg;
    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int OP_TIME_NS    = 2000;
    localparam int OP_CYCLES     =
        (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TMR_W         = 10;
    // ------------------------------------------------------------------
    // memory geometry
    // ------------------------------------------------------------------
    localparam int ADR_W         = 15;
    localparam int ADRH_W        = 7;
    localparam int DAT_W         = 14;
    localparam int DATH_W        = 6;
    localparam int LATCHES       = 32;
    localparam int LAT_IDX_W     = 5;
    localparam int UID_WORDS     = 4;
    localparam int FLASH_WORDS   = 32768;
    localparam logic [DAT_W-1:0] BLANK_WORD = 14'h3FFF;
    // ------------------------------------------------------------------
    // unlock key and configuration space map
    // ------------------------------------------------------------------
    localparam logic [7:0]  KEY_FIRST    = 8'h55;
    localparam logic [7:0]  KEY_SECOND   = 8'hAA;
    localparam logic [15:0] CFG_UID_LAST = 16'h8003;
    localparam logic [15:0] CFG_DEVID    = 16'h8006;
    localparam logic [15:0] CFG_WORD1    = 16'h8007;
    localparam logic [15:0] CFG_WORD2    = 16'h8008;
    // ------------------------------------------------------------------
    // register offsets (byte addresses) and padding
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_DATA_LO  = 8'h00;
    localparam logic [7:0] OFF_DATA_HI  = 8'h04;
    localparam logic [7:0] OFF_ADDR_LO  = 8'h08;
    localparam logic [7:0] OFF_ADDR_HI  = 8'h0C;
    localparam logic [7:0] OFF_CONTROL  = 8'h10;
    localparam logic [7:0] OFF_KEY      = 8'h14;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h1C;
    localparam logic [23:0] BUS_PAD     = 24'h00_0000;
    localparam logic [1:0]  DATH_PAD    = 2'h0;
    localparam logic        TOP_ONE     = 1'b1;
    localparam int IRQ_W     = 2;
    localparam int IRQ_DONE  = 0;
    localparam int IRQ_FAULT = 1;
    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic top;     // unimplemented, reads one
        logic cfg;     // config_space_select
        logic latch_load_only;    // latch_load_only
        logic free;    // erase select
        logic err;     // sequence_error_flag
        logic program_enable;    // program_enable
        logic wr;      // program trigger
        logic rd;      // read trigger
    } fspc_ctrl_t;
    typedef enum logic [2:0] {
        UL_IDLE  = 3'b001,
        UL_FIRST = 3'b010,
        UL_ARMED = 3'b100
    } fspc_unlock_t;
    typedef enum logic [2:0] {
        OP_IDLE  = 3'b001,
        OP_LOAD  = 3'b010,
        OP_TIMED = 3'b100
    } fspc_op_t;
endpackage

// ---- design/fspc_top.sv ----
// flash self program control: register slave, unlock, latches, array
// Functional notes
// - config select steers access to top half
// - user ids writable, id and config read-only
// - bad config read clears both data regs
// - data high holds six bits, top zero
// - address high holds seven bits, top one
// - control bit six picks config space
// - latch-only loads latch, else writes row
// - erase ignores the latch-only bit
// - erase bit selects erase, cleared when done
// - trigger attempt sets error, completion clears
// - program enable clear blocks load, write and erase cycles, not reads
// - trigger set-only, self-timed, hardware clears
// - read trigger set-only, one cycle, clears
// - latches return blank after write or erase
// - low five bits pick latch, row bounded
// - broken unlock starts no load or program
`timescale 1ns/1ps
`default_nettype none
module fspc_top
    import fspc_pkg::*;
#(
    parameter logic [DAT_W-1:0] DEVICE_ID    = 14'h0123, // arbitrary
    parameter logic [DAT_W-1:0] CONFIG_WORD1 = 14'h3FFF,
    parameter logic [DAT_W-1:0] CONFIG_WORD2 = 14'h3FFF
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // interrupt
    output logic             irq_o
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    fspc_ctrl_t           ctrl_q;
    fspc_unlock_t         unlock_q;
    fspc_op_t             op_q;
    logic [7:0]           datl_q;
    logic [DATH_W-1:0]    dath_q;
    logic [7:0]           adrl_q;
    logic [ADRH_W-1:0]    adrh_q;
    logic [TMR_W-1:0]     tmr_q;
    logic                 op_erase_q;
    logic                 op_latch_load_only_q;
    logic                 op_cfg_q;
    logic [IRQ_W-1:0]     stat_q;
    logic [IRQ_W-1:0]     mask_q;
    logic                 ack_q;
    logic [31:0]          dat_q;
    logic                 irq_q;
    logic [DAT_W-1:0]     latch_q [LATCHES];
    logic [DAT_W-1:0]     uid_q   [UID_WORDS];
    logic [DAT_W-1:0]     flash_mem [FLASH_WORDS];
    // ------------------------------------------------------------------
    // bus strobes and decode
    // ------------------------------------------------------------------
    logic                 req;
    logic                 wr_stb;
    logic                 rd_req;
    logic [ADR_W-1:0]     adr_q;
    logic [15:0]          cfg_addr;
    fspc_ctrl_t           wdat;
    logic hit_dlo, hit_dhi, hit_alo, hit_ahi;
    logic hit_ctl, hit_key, hit_sta, hit_msk;
    logic [7:0]           rmux;
    // a write lands at the edge where the master samples ack
    assign req      = wb_cyc_i & wb_stb_i;
    assign wr_stb   = req & ack_q & wb_we_i & wb_sel_i[0];
    assign rd_req   = req & ~ack_q & ~wb_we_i;
    assign adr_q    = {adrh_q, adrl_q};
    assign cfg_addr = {TOP_ONE, adr_q};
    assign wdat     = fspc_ctrl_t'(wb_dat_i[7:0]);
    // one-hot register select and the byte that a read of it returns
    always_comb begin
        hit_dlo = 1'b0;
        hit_dhi = 1'b0;
        hit_alo = 1'b0;
        hit_ahi = 1'b0;
        hit_ctl = 1'b0;
        hit_key = 1'b0;
        hit_sta = 1'b0;
        hit_msk = 1'b0;
        rmux    = '0;
        if (wb_adr_i == OFF_DATA_LO) begin
            hit_dlo = 1'b1;
            rmux    = datl_q;
        end else if (wb_adr_i == OFF_DATA_HI) begin
            hit_dhi = 1'b1;
            rmux    = {DATH_PAD, dath_q};
        end else if (wb_adr_i == OFF_ADDR_LO) begin
            hit_alo = 1'b1;
            rmux    = adrl_q;
        end else if (wb_adr_i == OFF_ADDR_HI) begin
            hit_ahi = 1'b1;
            rmux    = {TOP_ONE, adrh_q};
        end else if (wb_adr_i == OFF_CONTROL) begin
            hit_ctl = 1'b1;
            rmux    = ctrl_q;
        end else if (wb_adr_i == OFF_KEY) begin
            hit_key = 1'b1;                 // write-only, reads zero
        end else if (wb_adr_i == OFF_IRQ_STAT) begin
            hit_sta = 1'b1;
            rmux    = {6'h00, stat_q};
        end else if (wb_adr_i == OFF_IRQ_MASK) begin
            hit_msk = 1'b1;
            rmux    = {6'h00, mask_q};
        end
    end
    // ------------------------------------------------------------------
    // sequence control
    // ------------------------------------------------------------------
    logic trig_try, op_start, op_done, commit, key_wr;
    assign trig_try = wr_stb & hit_ctl & wdat.wr;
    // no cycle without enable and a completed key pair
    assign op_start = trig_try & (op_q == OP_IDLE) &
                      (unlock_q == UL_ARMED) & ctrl_q.program_enable;
    assign commit   = (op_q == OP_TIMED) & (tmr_q == '0);
    assign op_done  = commit | ((op_q == OP_LOAD) & op_latch_load_only_q);
    assign key_wr   = wr_stb & hit_key;
    // unlock detector; any other register write breaks the pair
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            unlock_q <= UL_IDLE;
        end else if (key_wr) begin
            case (unlock_q)
                UL_IDLE: begin
                    if (wb_dat_i[7:0] == KEY_FIRST && ctrl_q.program_enable) begin
                        unlock_q <= UL_FIRST;
                    end
                end
                UL_FIRST: begin
                    if (wb_dat_i[7:0] == KEY_SECOND) begin
                        unlock_q <= UL_ARMED;
                    end else begin
                        unlock_q <= UL_IDLE;
                    end
                end
                default: begin
                    unlock_q <= UL_IDLE;
                end
            endcase
        end else if (wr_stb) begin
            unlock_q <= UL_IDLE;
        end
    end
    // operation sequencer: one load cycle, then a self-timed phase unless latch-load-only
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            op_q       <= OP_IDLE;
            tmr_q      <= '0;
            op_erase_q <= 1'b0;
            op_latch_load_only_q  <= 1'b0;
            op_cfg_q   <= 1'b0;
        end else begin
            case (op_q)
                OP_IDLE: begin
                    if (op_start) begin
                        op_q       <= OP_LOAD;
                        op_erase_q <= wdat.free;
                        op_latch_load_only_q  <= wdat.latch_load_only & ~wdat.free;
                        op_cfg_q   <= wdat.cfg;
                    end
                end
                OP_LOAD: begin
                    if (op_latch_load_only_q) begin
                        op_q <= OP_IDLE;
                    end else begin
                        op_q  <= OP_TIMED;
                        tmr_q <= TMR_W'(OP_CYCLES - 1);
                    end
                end
                OP_TIMED: begin
                    if (tmr_q == '0) begin
                        op_q <= OP_IDLE;
                    end else begin
                        tmr_q <= tmr_q - 1'b1;
                    end
                end
                default: begin
                    op_q <= OP_IDLE;
                end
            endcase
        end
    end
    // control register; writes to it are held off while busy
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q     <= '0;
            ctrl_q.top <= TOP_ONE;
        end else begin
            if (wr_stb && hit_ctl && op_q == OP_IDLE) begin
                ctrl_q.cfg  <= wdat.cfg;
                ctrl_q.latch_load_only <= wdat.latch_load_only;
                ctrl_q.free <= wdat.free;
                ctrl_q.err  <= wdat.err;
                ctrl_q.program_enable <= wdat.program_enable;
                ctrl_q.rd   <= ctrl_q.rd | wdat.rd;
            end
            if (op_start) begin
                ctrl_q.wr <= 1'b1;
            end
            if (ctrl_q.rd) begin
                ctrl_q.rd <= 1'b0;
            end
            if (op_done) begin
                ctrl_q.wr  <= 1'b0;
                ctrl_q.err <= 1'b0;
                if (op_erase_q) begin
                    ctrl_q.free <= 1'b0;
                end
            end
            // a set attempt wins over completion in the same cycle
            if (trig_try) begin
                ctrl_q.err <= 1'b1;
            end
        end
    end
    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    logic [DAT_W-1:0] cfg_word;
    logic [DAT_W-1:0] rd_word;
    always_comb begin
        cfg_word = '0;
        if (cfg_addr <= CFG_UID_LAST) begin
            cfg_word = uid_q[adr_q[1:0]];
        end else if (cfg_addr == CFG_DEVID) begin
            cfg_word = DEVICE_ID;
        end else if (cfg_addr == CFG_WORD1) begin
            cfg_word = CONFIG_WORD1;
        end else if (cfg_addr == CFG_WORD2) begin
            cfg_word = CONFIG_WORD2;
        end
    end
    assign rd_word = ctrl_q.cfg ? cfg_word : flash_mem[adr_q];
    // data and address registers; a read result overrides a write
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            datl_q <= '0;
            dath_q <= '0;
            adrl_q <= '0;
            adrh_q <= '0;
        end else begin
            if (wr_stb && hit_dlo) begin
                datl_q <= wb_dat_i[7:0];
            end
            if (wr_stb && hit_dhi) begin
                dath_q <= wb_dat_i[DATH_W-1:0];
            end
            if (wr_stb && hit_alo) begin
                adrl_q <= wb_dat_i[7:0];
            end
            if (wr_stb && hit_ahi) begin
                adrh_q <= wb_dat_i[ADRH_W-1:0];
            end
            if (ctrl_q.rd) begin
                datl_q <= rd_word[7:0];
                dath_q <= rd_word[DAT_W-1:8];
            end
        end
    end
    // ------------------------------------------------------------------
    // write latches, user ids and the array
    // ------------------------------------------------------------------
    logic load_ok;
    assign load_ok = (op_q == OP_LOAD) & ~op_erase_q & ~op_cfg_q;
    for (genvar g = 0; g < LATCHES; g++) begin : g_latch
        always_ff @(posedge clock or negedge rst_b) begin
            if (!rst_b) begin
                latch_q[g] <= BLANK_WORD;
            end else if (commit) begin
                latch_q[g] <= BLANK_WORD;
            end else if (load_ok &&
                         adr_q[LAT_IDX_W-1:0] == LAT_IDX_W'(g)) begin
                latch_q[g] <= {dath_q, datl_q};
            end
        end
    end
    // user ids take the data word directly, no latch involved
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < UID_WORDS; i++) begin
                uid_q[i] <= BLANK_WORD;
            end
        end else if (commit && op_cfg_q && !op_erase_q &&
                     cfg_addr <= CFG_UID_LAST) begin
            uid_q[adr_q[1:0]] <= {dath_q, datl_q};
        end
    end
    // the array is non-volatile, so it has no reset; a row never wraps
    always_ff @(posedge clock) begin
        if (commit && !op_cfg_q) begin
            for (int i = 0; i < LATCHES; i++) begin
                flash_mem[{adr_q[ADR_W-1:LAT_IDX_W], LAT_IDX_W'(i)}] <=
                    op_erase_q ? BLANK_WORD : latch_q[i];
            end
        end
    end
    // ------------------------------------------------------------------
    // interrupts: sticky, write one to clear, set wins
    // ------------------------------------------------------------------
    logic [IRQ_W-1:0] evt;
    always_comb begin
        evt            = '0;
        evt[IRQ_DONE]  = op_done;
        evt[IRQ_FAULT] = trig_try & ~op_start;
    end
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            stat_q <= '0;
            mask_q <= '0;
            irq_q  <= 1'b0;
        end else begin
            if (wr_stb && hit_sta) begin
                stat_q <= (stat_q & ~wb_dat_i[IRQ_W-1:0]) | evt;
            end else begin
                stat_q <= stat_q | evt;
            end
            if (wr_stb && hit_msk) begin
                mask_q <= wb_dat_i[IRQ_W-1:0];
            end
            irq_q <= |(stat_q & mask_q);
        end
    end
    // ------------------------------------------------------------------
    // bus answer: ack one cycle after the request, data from a flop
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ack_q <= 1'b0;
            dat_q <= '0;
        end else begin
            ack_q <= req & ~ack_q;
            if (rd_req) begin
                dat_q <= {BUS_PAD, rmux};
            end
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign irq_o    = irq_q;
    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    localparam int A_OP_MAX = OP_CYCLES + 2; // timed phase plus clear edge
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    a_ack_single_pulse: assert property (
        ack_q |=> !ack_q) else $error("ack held two cycles");
    a_ack_after_req: assert property (
        req && !ack_q |=> ack_q) else $error("ack missing");
    a_rd_one_cycle: assert property (
        ctrl_q.rd |=> !ctrl_q.rd) else $error("read trigger stuck");
    a_start_needs_key: assert property (
        op_q == OP_IDLE ##1 op_q == OP_LOAD |->
        $past(unlock_q) == UL_ARMED) else $error("op without unlock");
    a_start_needs_en: assert property (
        $rose(ctrl_q.wr) |-> $past(ctrl_q.program_enable))
        else $error("op while disabled");
    a_err_on_trigger: assert property (
        trig_try |=> ctrl_q.err) else $error("error flag not set");
    a_op_bounded: assert property (
        $rose(op_q == OP_TIMED) |-> ##[1:A_OP_MAX] !ctrl_q.wr)
        else $error("trigger not cleared");
    a_latch_blank: assert property (
        commit |=> latch_q[0] == BLANK_WORD && latch_q[31] == BLANK_WORD)
        else $error("latch not blank");
    a_erase_clears: assert property (
        commit && op_erase_q |=> !ctrl_q.free)
        else $error("erase select kept");
    a_cfg_bad_zero: assert property (
        ctrl_q.rd && ctrl_q.cfg && (cfg_addr > CFG_WORD2 ||
        (cfg_addr > CFG_UID_LAST && cfg_addr < CFG_DEVID)) |=>
        datl_q == 8'h00 && dath_q == 6'h00) else $error("bad read not 0");
    a_addr_top_one: assert property (
        rd_req && hit_ahi |=> wb_dat_o[7]) else $error("top bit zero");

    c_load_only: cover property (op_q == OP_LOAD && op_latch_load_only_q);
    c_row_write: cover property (commit && !op_erase_q && !op_cfg_q);
    c_row_erase: cover property (commit && op_erase_q);
    c_cfg_read: cover property (ctrl_q.rd && ctrl_q.cfg);
endmodule // fspc_top
`default_nettype wire

// ---- tb/fspc_sw_model.sv ----
// core software side model: classic wishbone master into the block
`timescale 1ns/1ps
`default_nettype none
module fspc_sw_model
    import fspc_pkg::*;
(
    // clock
    input  wire logic        clock,
    // wishbone master
    output logic             wb_cyc_o,
    output logic             wb_stb_o,
    output logic             wb_we_o,
    output logic [7:0]       wb_adr_o,
    output logic [3:0]       wb_sel_o,
    output logic [31:0]      wb_dat_o,
    input  wire logic        wb_ack_i,
    input  wire logic [31:0] wb_dat_i
);
    // idle bus from time zero
    initial begin
        wb_cyc_o = 1'b0;
        wb_stb_o = 1'b0;
        wb_we_o  = 1'b0;
        wb_adr_o = 8'hFF;
        wb_sel_o = 4'h0;
        wb_dat_o = 32'h0000_0000;
    end
    // one classic cycle; released lines show the inverse, never stale data
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        @(posedge clock);
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o  <= w;
        wb_adr_o <= a;
        wb_sel_o <= 4'h1;
        wb_dat_o <= {24'h00_0000, d};
        do @(posedge clock); while (wb_ack_i !== 1'b1);
        q = wb_dat_i[7:0];
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        wb_adr_o <= ~a;
        wb_dat_o <= ~{24'h00_0000, d};
    endtask
    // ordered key pair; any other register write in between breaks the sequence
    task automatic unlock();
        logic [7:0] q;
        bus(1'b1, OFF_KEY, KEY_FIRST, q);
        bus(1'b1, OFF_KEY, KEY_SECOND, q);
    endtask
endmodule // fspc_sw_model
`default_nettype wire

// ---- tb/fspc_tb_top.sv ----
// self-checking testbench of the flash self program control
`timescale 1ns/1ps
`default_nettype none
module fspc_tb_top;
    import fspc_pkg::*;
    localparam logic [DAT_W-1:0] DEV_ID = 14'h0155; // arbitrary value
    localparam logic [DAT_W-1:0] CFG_W1 = 14'h1A5A;
    logic        clock = 1'b0;
    logic        rst_b = 1'b0;
    logic        cyc, stb, we, ack, irq;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat;
    int          n_fail = 0;
    int          n_tests = 0;
    // clock and instances
    always #2.5 clock = ~clock;
    fspc_top #(.DEVICE_ID(DEV_ID), .CONFIG_WORD1(CFG_W1)) i_fspc_top (
        .clock(clock), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq));
    fspc_sw_model i_fspc_sw_model (
        .clock(clock), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we),
        .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat),
        .wb_ack_i(ack), .wb_dat_i(rdat));
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        i_fspc_sw_model.bus(1'b1, a, d, q);
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        i_fspc_sw_model.bus(1'b0, a, 8'h00, q);
        chk(q, exp);
    endtask
    // start a read of one word and compare both data bytes
    task automatic word(input logic [7:0] c, a, lo, hi);
        wr(OFF_ADDR_LO, a);
        wr(OFF_CONTROL, c);
        rc(OFF_DATA_LO, lo);
        rc(OFF_DATA_HI, hi);
    endtask
    // unlocked trigger, then poll until hardware drops the trigger bit
    task automatic prog(input logic [7:0] c, a, lo, hi);
        logic [7:0] q;
        wr(OFF_ADDR_LO, a);
        wr(OFF_DATA_LO, lo);
        wr(OFF_DATA_HI, hi);
        wr(OFF_CONTROL, c);
        i_fspc_sw_model.unlock();
        wr(OFF_CONTROL, c | 8'h02);
        q = 8'h02;
        for (int i = 0; i < 300 && q[1] !== 1'b0; i++)
            i_fspc_sw_model.bus(1'b0, OFF_CONTROL, 8'h00, q);
        chk(q & 8'h02, 8'h00);
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_regs();
        rc(OFF_CONTROL, 8'h80);
        rc(OFF_ADDR_HI, 8'h80);
        wr(OFF_ADDR_HI, 8'h7F);
        rc(OFF_ADDR_HI, 8'hFF);
        wr(OFF_ADDR_HI, 8'h00);
        wr(OFF_DATA_HI, 8'hFF);
        rc(OFF_DATA_HI, 8'h3F);
        rc(OFF_KEY, 8'h00);
        rc(8'h20, 8'h00);
        $display("test regs done");
    endtask
    task automatic t_refuse();
        wr(OFF_CONTROL, 8'h00);
        i_fspc_sw_model.unlock();
        wr(OFF_CONTROL, 8'h02);
        rc(OFF_CONTROL, 8'h88);
        wr(OFF_CONTROL, 8'h04);
        wr(OFF_KEY, KEY_FIRST);
        wr(OFF_ADDR_LO, 8'h00);  // interrupts the key pair
        wr(OFF_KEY, KEY_SECOND);
        wr(OFF_CONTROL, 8'h06);
        rc(OFF_CONTROL, 8'h8C);
        rc(OFF_IRQ_STAT, 8'h02);
        chk({7'h00, irq}, 8'h00);
        wr(OFF_IRQ_MASK, 8'h02);
        rc(OFF_IRQ_MASK, 8'h02);
        chk({7'h00, irq}, 8'h01);
        wr(OFF_IRQ_STAT, 8'h02);
        rc(OFF_IRQ_STAT, 8'h00);
        chk({7'h00, irq}, 8'h00);
        $display("test refuse done");
    endtask
    task automatic t_cfg();
        word(8'h41, 8'h00, 8'hFF, 8'h3F);
        rc(OFF_CONTROL, 8'hC0);
        word(8'h41, 8'h06, DEV_ID[7:0], {2'h0, DEV_ID[13:8]});
        word(8'h41, 8'h05, 8'h00, 8'h00);
        word(8'h41, 8'h07, CFG_W1[7:0], {2'h0, CFG_W1[13:8]});
        prog(8'h44, 8'h06, 8'h00, 8'h00);
        word(8'h41, 8'h06, DEV_ID[7:0], {2'h0, DEV_ID[13:8]});
        prog(8'h44, 8'h02, 8'h11, 8'h22);
        word(8'h41, 8'h02, 8'h11, 8'h22);
        prog(8'h54, 8'h02, 8'h00, 8'h00);
        rc(OFF_CONTROL, 8'hC4);
        word(8'h41, 8'h02, 8'h11, 8'h22);
        $display("test cfg done");
    endtask
    task automatic t_prog();
        prog(8'h34, 8'h00, 8'h00, 8'h00);
        rc(OFF_CONTROL, 8'hA4);
        word(8'h05, 8'h00, 8'hFF, 8'h3F);
        prog(8'h24, 8'h21, 8'h34, 8'h12);
        word(8'h05, 8'h01, 8'hFF, 8'h3F);
        prog(8'h04, 8'h22, 8'hBC, 8'h0A);
        word(8'h05, 8'h21, 8'h34, 8'h12);
        word(8'h05, 8'h22, 8'hBC, 8'h0A);
        word(8'h05, 8'h23, 8'hFF, 8'h3F);
        word(8'h05, 8'h02, 8'hFF, 8'h3F);
        prog(8'h04, 8'h03, 8'h00, 8'h00);
        word(8'h05, 8'h01, 8'hFF, 8'h3F);
        rc(OFF_CONTROL, 8'h84);
        rc(OFF_IRQ_STAT, 8'h01);
        $display("test prog done");
    endtask
    // ------------------------------------------------------------------
    // sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clock);
        rst_b <= 1'b1;
        t_regs();
        t_refuse();
        t_cfg();
        t_prog();
        test_done();
    end
    // the run needs well under 10000 cycles; cut a hang at 20000
    initial begin
        #100000;
        n_fail++;
        test_done();
    end
endmodule // fspc_tb_top
`default_nettype wire
